// >>> hw/ciex_pkg.sv
package ciex_pkg;

	// datapath widths
	localparam int DATA_W = 8;
	localparam int FILE_AW = 7;
	localparam int FILE_DEPTH = 128;
	localparam int LIT_W = 11;
	localparam int PC_W = 13;

	// upper address latch width and the two bits that feed the program counter top
	localparam int LATCH_W = 5;
	localparam int LATCH_PC_HI = 4;
	localparam int LATCH_PC_LO = 3;

	// return stack geometry
	localparam int STACK_DEPTH = 8;
	localparam int STACK_AW = 3;

	// constant values
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [DATA_W-1:0] WDT_CLEAR_VALUE = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
	localparam logic [STACK_AW-1:0] STACK_PTR_RESET = 3'h0;
	localparam logic [STACK_AW-1:0] STACK_PTR_STEP = 3'h1;

	// destination select bit
	localparam logic DEST_ACCUM = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// status flag reset values
	localparam logic NULL_FLAG_RESET = 1'b0;
	localparam logic EXPIRY_FLAG_RESET = 1'b1;
	localparam logic SLEEP_FLAG_RESET = 1'b1;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_KICK_WATCHDOG,
		OP_SUBROUTINE_JUMP,
		OP_INVERT_FILE,
		OP_ZERO_FILE,
		OP_ZERO_ACCUM,
		OP_MINUS_ONE_FILE,
		OP_MINUS_ONE_SKIP
	} ciex_op_e;

	typedef enum logic [1:0] {
		PH_ISSUE,
		PH_JUMP_FILL,
		PH_SKIP_NOP
	} ciex_phase_e;

endpackage

// >>> hw/ciex_core.sv
// Behaviour
// - kick_watchdog_op loads zero into watchdog counter and clears its prescaler.
// - kick_watchdog_op sets watchdog_expiry_flag and sleep_entry_flag to one.
// - subroutine_jump_op pushes program_counter plus one as new return stack top.
// - subroutine_jump_op loads 11-bit literal into program_counter bits 10 to 0.
// - subroutine_jump_op fills program_counter bits 12:11 from latch bits 4:3.
// - subroutine_jump_op takes two instruction cycles and leaves status flags alone.
// - destination bit 0 writes accumulator, bit 1 writes addressed file register.
// - file operand is a 7-bit address, 0 through 127.
// - invert_file_op writes inverse of file to destination and updates null flag.
// - zero_file_op clears addressed file register and sets null flag.
// - zero_accum_op clears accumulator and sets null flag.
// - minus_one_file_op writes file minus one to destination, updates null flag.
// - minus_one_skip_op decrements; zero result discards next instruction, two cycles.
`timescale 1ns/1ps
`default_nettype none

module ciex_core
	import ciex_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// instruction issue
	input wire logic op_valid,
	input wire ciex_op_e op_code,
	input wire logic [FILE_AW-1:0] op_file,
	input wire logic op_dest,
	input wire logic [LIT_W-1:0] op_literal,
	output logic op_ready,
	// upper address latch load
	input wire logic latch_wr_en,
	input wire logic [LATCH_W-1:0] latch_wr_data,
	// file register side port
	input wire logic file_wr_en,
	input wire logic [FILE_AW-1:0] file_wr_addr,
	input wire logic [DATA_W-1:0] file_wr_data,
	input wire logic [FILE_AW-1:0] file_rd_addr,
	output logic [DATA_W-1:0] file_rd_data,
	// watchdog and sleep events
	input wire logic watchdog_expired,
	input wire logic sleep_entered,
	output logic watchdog_clear,
	output logic prescaler_clear,
	output logic [DATA_W-1:0] watchdog_load_value,
	// core state
	output logic [PC_W-1:0] program_counter,
	output logic [PC_W-1:0] return_stack_top,
	output logic [STACK_AW-1:0] stack_ptr,
	output logic [DATA_W-1:0] accum,
	output logic [LATCH_W-1:0] upper_address_latch,
	output logic null_result_flag,
	output logic watchdog_expiry_flag,
	output logic sleep_entry_flag,
	output logic skip_taken
);

	function automatic logic [DATA_W-1:0] minus_one(input logic [DATA_W-1:0] val);
		minus_one = val - ONE_BYTE;
	endfunction

	function automatic logic result_is_zero(input logic [DATA_W-1:0] val);
		result_is_zero = (val == ZERO_BYTE);
	endfunction

	function automatic logic op_is(input ciex_op_e code, input ciex_op_e want);
		op_is = (code == want);
	endfunction

	// pointer wraps modulo its width, which makes the stack circular
	function automatic logic [STACK_AW-1:0] stack_advance(input logic [STACK_AW-1:0] ptr);
		stack_advance = ptr + STACK_PTR_STEP;
	endfunction

	logic [DATA_W-1:0] file_mem [FILE_DEPTH];
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	ciex_phase_e phase;
	ciex_phase_e next_phase;
	logic [PC_W-1:0] next_program_counter;
	logic [DATA_W-1:0] next_accum;
	logic next_null_result_flag;

	// issue decode
	wire logic issue = op_valid && op_ready;
	wire logic is_kick = issue && op_is(op_code, OP_KICK_WATCHDOG);
	wire logic is_jump = issue && op_is(op_code, OP_SUBROUTINE_JUMP);
	wire logic is_invert = issue && op_is(op_code, OP_INVERT_FILE);
	wire logic is_zero_file = issue && op_is(op_code, OP_ZERO_FILE);
	wire logic is_zero_accum = issue && op_is(op_code, OP_ZERO_ACCUM);
	wire logic is_minus = issue && op_is(op_code, OP_MINUS_ONE_FILE);
	wire logic is_skip = issue && op_is(op_code, OP_MINUS_ONE_SKIP);

	// operand fetch over the full 7-bit space
	wire logic [DATA_W-1:0] file_operand = file_mem[op_file];
	wire logic [DATA_W-1:0] decremented = minus_one(file_operand);

	// arithmetic result for the ops that honour the destination bit
	wire logic dest_op = is_invert || is_minus || is_skip;
	wire logic [DATA_W-1:0] dest_result = is_invert ? ~file_operand : decremented;
	wire logic dest_result_zero = result_is_zero(dest_result);

	// destination steering
	wire logic write_accum_from_op = dest_op && (op_dest == DEST_ACCUM);
	wire logic write_file_from_op = dest_op && (op_dest == DEST_FILE);

	// null flag update: skip variant and jump leave it alone
	wire logic null_from_result = is_invert || is_minus;
	wire logic null_force_set = is_zero_file || is_zero_accum;

	// skip decision on the decrement result
	wire logic skip_now = is_skip && result_is_zero(decremented);

	// jump target
	wire logic [PC_W-1:0] pc_plus_one = program_counter + PC_STEP;
	wire logic [PC_W-1:0] jump_target = {upper_address_latch[LATCH_PC_HI:LATCH_PC_LO],
		op_literal};
	wire logic in_skip_nop = (phase == PH_SKIP_NOP);

	// the push lands one slot above the current top and the pointer follows it
	wire logic [STACK_AW-1:0] push_slot = stack_advance(stack_ptr);

	// one write port into the file memory: the core wins over the side port
	wire logic core_file_wr = is_zero_file || write_file_from_op;
	wire logic file_wr_any = core_file_wr || file_wr_en;
	wire logic [FILE_AW-1:0] file_wr_sel_addr = core_file_wr ? op_file : file_wr_addr;
	wire logic [DATA_W-1:0] core_file_val = is_zero_file ? ZERO_BYTE : dest_result;
	wire logic [DATA_W-1:0] file_wr_val = core_file_wr ? core_file_val : file_wr_data;

	// ready drops for the dead cycle of a jump or a taken skip
	assign op_ready = (phase == PH_ISSUE);
	assign return_stack_top = stack_mem[stack_ptr];
	assign watchdog_load_value = WDT_CLEAR_VALUE;

	always_comb begin
		next_phase = phase;
		unique case (phase)
			PH_ISSUE: begin
				if (is_jump) begin
					next_phase = PH_JUMP_FILL;
				end else if (skip_now) begin
					next_phase = PH_SKIP_NOP;
				end
			end
			PH_JUMP_FILL: begin
				next_phase = PH_ISSUE;
			end
			PH_SKIP_NOP: begin
				next_phase = PH_ISSUE;
			end
			default: begin
				// the unused phase code falls back to issue
				next_phase = PH_ISSUE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase <= PH_ISSUE;
		end else begin
			phase <= next_phase;
		end
	end

	// program counter: the skip cycle steps past the discarded instruction
	always_comb begin
		next_program_counter = program_counter;
		if (is_jump) begin
			next_program_counter = jump_target;
		end else if (issue || in_skip_nop) begin
			next_program_counter = pc_plus_one;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			program_counter <= PC_RESET;
		end else begin
			program_counter <= next_program_counter;
		end
	end

	// eight slots; a ninth nested push overwrites the oldest return address
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stack_ptr <= STACK_PTR_RESET;
		end else if (is_jump) begin
			stack_ptr <= push_slot;
		end
	end

	// stack contents are not reset, only the pointer is
	always_ff @(posedge sys_clk) begin
		if (is_jump) begin
			stack_mem[push_slot] <= pc_plus_one;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			upper_address_latch <= LATCH_RESET;
		end else if (latch_wr_en) begin
			upper_address_latch <= latch_wr_data;
		end
	end

	// single write port, steered by the wires above
	always_ff @(posedge sys_clk) begin
		if (file_wr_any) begin
			file_mem[file_wr_sel_addr] <= file_wr_val;
		end
	end

	always_ff @(posedge sys_clk) begin
		file_rd_data <= file_mem[file_rd_addr];
	end

	// next value of the accumulator
	always_comb begin
		next_accum = accum;
		if (is_zero_accum) begin
			next_accum = ZERO_BYTE;
		end else if (write_accum_from_op) begin
			next_accum = dest_result;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			accum <= ZERO_BYTE;
		end else begin
			accum <= next_accum;
		end
	end

	always_comb begin
		next_null_result_flag = null_result_flag;
		if (null_force_set) begin
			next_null_result_flag = 1'h1;
		end else if (null_from_result) begin
			next_null_result_flag = dest_result_zero;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			null_result_flag <= NULL_FLAG_RESET;
		end else begin
			null_result_flag <= next_null_result_flag;
		end
	end

	// the kick wins over a same-cycle expiry event
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			watchdog_expiry_flag <= EXPIRY_FLAG_RESET;
		end else if (is_kick) begin
			watchdog_expiry_flag <= 1'h1;
		end else if (watchdog_expired) begin
			watchdog_expiry_flag <= 1'h0;
		end
	end

	// the kick wins over a same-cycle sleep event
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sleep_entry_flag <= SLEEP_FLAG_RESET;
		end else if (is_kick) begin
			sleep_entry_flag <= 1'h1;
		end else if (sleep_entered) begin
			sleep_entry_flag <= 1'h0;
		end
	end

	// registered so the watchdog sees a clean one-cycle strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			watchdog_clear <= 1'h0;
		end else begin
			watchdog_clear <= is_kick;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prescaler_clear <= 1'h0;
		end else begin
			prescaler_clear <= is_kick;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			skip_taken <= 1'h0;
		end else begin
			skip_taken <= skip_now;
		end
	end

endmodule

`default_nettype wire

// >>> tb/ciex_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ciex_core_checker
	import ciex_pkg::*;
(
	// watched ports
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic op_valid,
	input wire ciex_op_e op_code,
	input wire logic op_ready,
	input wire logic [LIT_W-1:0] op_literal,
	input wire logic watchdog_clear,
	input wire logic prescaler_clear,
	input wire logic [DATA_W-1:0] watchdog_load_value,
	input wire logic [PC_W-1:0] program_counter,
	input wire logic [PC_W-1:0] return_stack_top,
	input wire logic [DATA_W-1:0] accum,
	input wire logic [LATCH_W-1:0] upper_address_latch,
	input wire logic null_result_flag,
	input wire logic watchdog_expiry_flag,
	input wire logic sleep_entry_flag,
	input wire logic skip_taken
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic tk = op_valid && op_ready;
	kick_out_a: assert property (tk && op_code == OP_KICK_WATCHDOG |=>
		watchdog_clear && prescaler_clear && watchdog_expiry_flag && sleep_entry_flag)
		else $error("kick outputs wrong");
	load_zero_a: assert property (watchdog_clear |-> watchdog_load_value == 8'h00)
		else $error("load value wrong");
	jump_pc_a: assert property (tk && op_code == OP_SUBROUTINE_JUMP |=>
		program_counter == {$past(upper_address_latch[4:3]), $past(op_literal)})
		else $error("jump target wrong");
	jump_push_a: assert property (tk && op_code == OP_SUBROUTINE_JUMP |=>
		return_stack_top == $past(program_counter) + 13'h0001) else $error("push wrong");
	jump_wait_a: assert property (tk && op_code == OP_SUBROUTINE_JUMP |=>
		!op_ready ##1 op_ready) else $error("jump cycles wrong");
	jump_flag_a: assert property (tk && op_code == OP_SUBROUTINE_JUMP |=>
		$stable(null_result_flag)) else $error("jump touched flag");
	clr_acc_a: assert property (tk && op_code == OP_ZERO_ACCUM |=>
		accum == 8'h00 && null_result_flag) else $error("clear accum wrong");
	skip_flag_a: assert property (tk && op_code == OP_MINUS_ONE_SKIP |=>
		$stable(null_result_flag)) else $error("skip touched flag");
	skip_nop_a: assert property (skip_taken |-> !op_ready ##1 op_ready)
		else $error("skip cycles wrong");
	kick_c: cover property (tk && op_code == OP_KICK_WATCHDOG);
	jump_c: cover property (tk && op_code == OP_SUBROUTINE_JUMP);
	skip_c: cover property (skip_taken);
endmodule
bind ciex_core ciex_core_checker u_chk (.*);
`default_nettype wire

// >>> tb/ciex_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ciex_core_tb
	import ciex_pkg::*;
;
	logic sys_clk = 1'h0, srst = 1'h1, op_valid = 1'h0, op_dest = 1'h0, latch_wr_en = 1'h0;
	logic file_wr_en = 1'h0, watchdog_expired = 1'h0, sleep_entered = 1'h0;
	ciex_op_e op_code = OP_IDLE;
	logic [FILE_AW-1:0] op_file = 7'h00, file_wr_addr = 7'h00, file_rd_addr = 7'h00;
	logic [LIT_W-1:0] op_literal = 11'h000;
	logic [LATCH_W-1:0] latch_wr_data = 5'h00;
	logic [DATA_W-1:0] file_wr_data = 8'h00;
	logic op_ready, watchdog_clear, prescaler_clear, null_result_flag;
	logic watchdog_expiry_flag, sleep_entry_flag, skip_taken;
	logic [DATA_W-1:0] file_rd_data, watchdog_load_value, accum;
	logic [PC_W-1:0] program_counter, return_stack_top;
	logic [STACK_AW-1:0] stack_ptr;
	logic [LATCH_W-1:0] upper_address_latch;
	int bad_count = 0, checks_done = 0, cycles = 0;
	always #2.5 sys_clk = ~sys_clk;
	ciex_core u_dut (.*);
	task chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// lets one edge pass with valid low, then waits out dead cycles so no offer is refused
	task issue(input ciex_op_e op, input logic [6:0] f, input logic d, input logic [10:0] k);
		do @(negedge sys_clk); while (op_ready !== 1'h1);
		op_valid = 1'h1;
		op_code = op;
		op_file = f;
		op_dest = d;
		op_literal = k;
		@(negedge sys_clk);
		op_valid = 1'h0;
	endtask
	task wrf(input logic [6:0] a, input logic [7:0] v);
		file_wr_en = 1'h1;
		file_wr_addr = a;
		file_wr_data = v;
		@(negedge sys_clk);
		file_wr_en = 1'h0;
	endtask
	task rdf(input logic [6:0] a, input logic [7:0] e);
		file_rd_addr = a;
		@(negedge sys_clk);
		chk(file_rd_data, e);
	endtask
	task t_kick;
		watchdog_expired = 1'h1;
		sleep_entered = 1'h1;
		@(negedge sys_clk);
		watchdog_expired = 1'h0;
		sleep_entered = 1'h0;
		chk({watchdog_expiry_flag, sleep_entry_flag}, 13'h0000);
		issue(OP_KICK_WATCHDOG, 7'h00, 1'h0, 11'h000);
		chk({watchdog_clear, prescaler_clear, watchdog_expiry_flag, sleep_entry_flag}, 13'h000F);
		chk(watchdog_load_value, 13'h0000);
		@(negedge sys_clk);
		chk({watchdog_clear, prescaler_clear}, 13'h0000);
	endtask
	// latch bits 2:0 set so a wrong slice shows up
	task t_jump;
		latch_wr_en = 1'h1;
		latch_wr_data = 5'h0F;
		@(negedge sys_clk);
		latch_wr_en = 1'h0;
		chk(upper_address_latch, 13'h000F);
		issue(OP_SUBROUTINE_JUMP, 7'h00, 1'h0, 11'h7FE);
		chk(op_ready, 13'h0000);
		chk(program_counter, 13'h0FFE);
		issue(OP_SUBROUTINE_JUMP, 7'h00, 1'h0, 11'h123);
		chk(return_stack_top, 13'h0FFF);
		chk(program_counter, 13'h0923);
		chk(stack_ptr, 13'h0002);
	endtask
	task t_arith;
		wrf(7'h7F, 8'h01);
		issue(OP_MINUS_ONE_FILE, 7'h7F, 1'h0, 11'h000);
		chk({accum, null_result_flag}, 13'h0001);
		issue(OP_INVERT_FILE, 7'h7F, 1'h1, 11'h000);
		chk(null_result_flag, 13'h0000);
		rdf(7'h7F, 8'hFE);
		issue(OP_MINUS_ONE_SKIP, 7'h7F, 1'h1, 11'h000);
		chk(skip_taken, 13'h0000);
		rdf(7'h7F, 8'hFD);
		wrf(7'h00, 8'h01);
		issue(OP_MINUS_ONE_SKIP, 7'h00, 1'h0, 11'h000);
		chk({skip_taken, op_ready, accum, null_result_flag}, 13'h0400);
		wrf(7'h05, 8'hAA);
		issue(OP_ZERO_FILE, 7'h05, 1'h1, 11'h000);
		chk(null_result_flag, 13'h0001);
		rdf(7'h05, 8'h00);
		issue(OP_INVERT_FILE, 7'h05, 1'h0, 11'h000);
		chk({accum, null_result_flag}, 13'h01FE);
		issue(OP_ZERO_ACCUM, 7'h00, 1'h0, 11'h000);
		chk({accum, null_result_flag}, 13'h0001);
	endtask
	task conclude;
		$display("mismatches %0d, checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// the whole run needs well under a hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			conclude;
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		srst = 1'h0;
		t_kick;
		t_jump;
		t_arith;
		conclude;
	end
endmodule
`default_nettype wire
